//--- src/ccg_defines.svh
// register map, field positions, reset values and counts of the clock control block
// assumes a 32-bit APB slave; each register is one aligned word at four times its index
//
// Function
// - The lock flag at bit 3 reads 1 once 64 PLL clock cycles have passed since power-up or generator clear, else 0.
// - With the divide enable bit 9 at 0 both output dividers are bypassed; at 1 the fixed halving is active and bit 8 picks the other.
// - The divider use bit 8 inserts the programmable divider when 1; the fixed halving stays regardless.
// - The programmable divider divides by the 6-bit ratio plus 4, and its result is then halved.
// - The clock-off flag enables or disables the clock pin, which floats when disabled.
// - Even source codes drive the PLL output onto the pin; code 1h holds it high, 3h and 5h low.
// - Source codes 7h and Fh drive the USB PLL clock; code Bh, the reset default, drives the system clock.
// - The power-down bit powers the PLL down at 1 and up at 0; power-up restarts the lock count.
// - The read-only system source field at bits 5-4 reports bypass or PLL mode and the input source.
`ifndef CCG_DEFINES_SVH
`define CCG_DEFINES_SVH

`define CCG_IDX_CFG1       14'h1C1E
`define CCG_IDX_CFG2       14'h1C1F
`define CCG_IDX_GEN3       14'h1C22
`define CCG_IDX_GEN4       14'h1C23
`define CCG_IDX_PINSRC     14'h1C24
`define CCG_IDX_MISC       14'h1C25
`define CCG_IDX_IRQST      14'h1C26
`define CCG_IDX_IRQEN      14'h1C27
`define CCG_IDX_IRQCLR     14'h1C28

`define CCG_GEN3_INIT_HI   12'h080
`define CCG_GEN3_INIT_LO   3'h6
`define CCG_GEN3_LOCK_BIT  3
`define CCG_GEN4_EN_BIT    9
`define CCG_GEN4_USE_BIT   8
`define CCG_PINSRC_RESET   4'hB
`define CCG_MISC_OFF_BIT   0
`define CCG_MISC_PD_BIT    1
`define CCG_MISC_CLR_BIT   2
`define CCG_MISC_OFF_RESET 1'b1
`define CCG_MISC_PD_RESET  1'b1
`define CCG_MISC_CLR_RESET 1'b0
`define CCG_IRQ_LOCK_BIT   0
`define CCG_IRQ_SWITCH_BIT 1
`define CCG_RATIO_OFFSET   7'h04
`define CCG_LOCK_CYCLES    64

`endif

//--- src/ccg_pkg.sv
// shared types of the clock control block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package ccg_pkg;
    typedef enum logic [2:0] {SRC_PLL, SRC_HIGH, SRC_LOW, SRC_USB, SRC_SYS} ccg_src_e;
    typedef logic [5:0] ccg_ratio_t;
endpackage
`default_nettype wire

//--- src/ccg_div_if.sv
// carrier between the control registers and the output divider chain
// assumes one clock shared by both ends
`default_nettype none
interface ccg_div_if;
    logic              enable;
    logic              use_div;
    logic              clear;
    ccg_pkg::ccg_ratio_t ratio;
    logic              tick;
    logic              level;
    modport ctrl (output enable, output use_div, output clear, output ratio, input tick, input level);
    modport div  (input enable, input use_div, input clear, input ratio, output tick, output level);
endinterface
`default_nettype wire

//--- src/ccg_out_divider.sv
// output divider chain: programmable divider then fixed halving, as a level toggling per tick
// assumes pclk is the PLL output; one toggle per pclk cycle stands for the undivided clock
`include "ccg_defines.svh"
`default_nettype none
module ccg_out_divider (
    input  wire logic pclk,    // pll output clock
    input  wire logic presetn, // async reset, active low
    ccg_div_if.div    dif      // divider config and result
);
    logic [7:0] cnt_reg;
    logic [7:0] term;
    logic [6:0] ratio4;

    always_comb begin
        ratio4 = {1'b0, dif.ratio} + `CCG_RATIO_OFFSET;
        if (!dif.enable) begin
            term = 8'h00;
        end else if (!dif.use_div) begin
            term = 8'h01;
        end else begin
            term = {ratio4, 1'b0} - 8'h01;
        end
    end

    // >= so a shrunk ratio cannot strand the counter above its end
    assign dif.tick = (cnt_reg >= term);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
        end else if (dif.clear || dif.tick) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dif.level <= 1'b0;
        end else if (dif.clear) begin
            dif.level <= 1'b0;
        end else if (dif.tick) begin
            dif.level <= !dif.level;
        end
    end
endmodule // ccg_out_divider
`default_nettype wire

//--- src/ccg_lock_monitor.sv
// lock status monitor: counts PLL cycles after power-up or clear
// assumes restart is a registered level from the control registers
`default_nettype none
module ccg_lock_monitor #(
    parameter int LOCK_CYCLES = 64
) (
    input  wire logic pclk,    // pll output clock
    input  wire logic presetn, // async reset, active low
    input  wire logic restart, // power-down or generator clear
    output logic      locked   // lock status flag
);
    logic [7:0] cnt_reg;
    localparam logic [7:0] LAST = 8'(LOCK_CYCLES - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
        end else if (restart) begin
            cnt_reg <= 8'h00;
        end else if (!locked) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked <= 1'b0;
        end else if (restart) begin
            locked <= 1'b0;
        end else if (cnt_reg == LAST) begin
            locked <= 1'b1;
        end
    end

    lock_at_count_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cnt_reg == LAST && !restart) |=> locked && $rose(locked))
        else $error("lock flag not set at end of count");
    restart_clears_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        restart ##1 !restart |-> !locked [*8])
        else $error("lock flag set too early after restart");
endmodule // ccg_lock_monitor
`default_nettype wire

//--- src/ccg_clock_control.sv
// clock control back end: lock monitor, output divider, clock pin source select, APB registers
// assumes pclk is the PLL output and system_clock, usb_pll_clock, select_pin are pclk-synchronous
`include "ccg_defines.svh"
`default_nettype none
module ccg_clock_control #(
    parameter int LOCK_CYCLES = `CCG_LOCK_CYCLES
) (
    input  wire logic        pclk,              // pll output clock
    input  wire logic        presetn,           // async reset, active low
    input  wire logic        psel,              // apb select
    input  wire logic        penable,           // apb enable
    input  wire logic        pwrite,            // apb direction
    input  wire logic [15:0] paddr,             // apb byte address
    input  wire logic [31:0] pwdata,            // apb write data
    output logic      [31:0] prdata,            // apb read data
    output logic             pready,            // apb ready
    output logic             pslverr,           // apb error
    input  wire logic        system_clock,      // system clock level
    input  wire logic        usb_pll_clock,     // usb pll clock level
    input  wire logic        select_pin,        // external clock input chosen
    output logic             system_source_select, // pll mode select
    output logic             pll_power_down,    // pll power down
    output logic             generator_clear_n, // generator clear, active low
    output logic             clock_out_pin,     // clock pin data
    output logic             clock_out_oe,      // clock pin drive enable
    output logic             irq                // level interrupt
);
    ccg_div_if dif ();

    logic [13:0] idx;
    logic        hit;
    logic        setup;
    logic        wr_en;
    logic [31:0] rd_mux;
    logic [31:0] prdata_reg;
    logic [11:0] init_hi_reg;
    logic [2:0]  init_lo_reg;
    logic        od_en_reg;
    logic        od_use_reg;
    logic [5:0]  od_ratio_reg;
    logic [3:0]  src_code_reg;
    logic        sys_sel_reg;
    logic        clk_off_reg;
    logic        pwrdn_reg;
    logic        clr_n_reg;
    logic [1:0]  irq_st_reg;
    logic [1:0]  irq_en_reg;
    logic [1:0]  events;
    logic        locked;
    logic        locked_d_reg;
    logic        want_lvl;
    logic        act_lvl;
    logic        pin_reg;
    logic        switch_ok;
    ccg_pkg::ccg_src_e want_kind;
    ccg_pkg::ccg_src_e active_kind_reg;

    function automatic ccg_pkg::ccg_src_e src_kind(input logic [3:0] code);
        if (!code[0]) begin
            src_kind = ccg_pkg::SRC_PLL;
        end else begin
            case (code)
                4'h1:          src_kind = ccg_pkg::SRC_HIGH;
                4'h7, 4'hF:    src_kind = ccg_pkg::SRC_USB;
                4'hB:          src_kind = ccg_pkg::SRC_SYS;
                default:       src_kind = ccg_pkg::SRC_LOW;
            endcase
        end
    endfunction

    function automatic logic is_const(input ccg_pkg::ccg_src_e k);
        is_const = (k == ccg_pkg::SRC_HIGH) || (k == ccg_pkg::SRC_LOW);
    endfunction

    // bus decode; misaligned or unknown words answer with pslverr
    assign idx   = paddr[15:2];
    assign setup = psel && !penable;
    always_comb begin
        case (idx)
            `CCG_IDX_CFG1, `CCG_IDX_CFG2, `CCG_IDX_GEN3, `CCG_IDX_GEN4, `CCG_IDX_PINSRC,
            `CCG_IDX_MISC, `CCG_IDX_IRQST, `CCG_IDX_IRQEN, `CCG_IDX_IRQCLR: hit = (paddr[1:0] == 2'h0);
            default: hit = 1'b0;
        endcase
    end
    assign wr_en   = psel && penable && pwrite && hit;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            `CCG_IDX_CFG1:   rd_mux = 32'h0000_0000;
            `CCG_IDX_CFG2:   rd_mux = {26'h0, select_pin, sys_sel_reg, 1'b0, select_pin, 1'b0, sys_sel_reg};
            `CCG_IDX_GEN3:   rd_mux = {16'h0, init_hi_reg, locked, init_lo_reg};
            `CCG_IDX_GEN4:   rd_mux = {22'h0, od_en_reg, od_use_reg, 2'h0, od_ratio_reg};
            `CCG_IDX_PINSRC: rd_mux = {28'h0, src_code_reg};
            `CCG_IDX_MISC:   rd_mux = {29'h0, clr_n_reg, pwrdn_reg, clk_off_reg};
            `CCG_IDX_IRQST:  rd_mux = {30'h0, irq_st_reg};
            `CCG_IDX_IRQEN:  rd_mux = {30'h0, irq_en_reg};
            default:         rd_mux = 32'h0000_0000;
        endcase
        if (paddr[1:0] != 2'h0) begin
            rd_mux = 32'h0000_0000;
        end
    end

    // read data caught in the setup cycle so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_reg <= rd_mux;
        end
    end
    assign prdata = prdata_reg;

    // generator control three: init field only, lock bit is read-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_hi_reg <= `CCG_GEN3_INIT_HI;
            init_lo_reg <= `CCG_GEN3_INIT_LO;
        end else if (wr_en && idx == `CCG_IDX_GEN3) begin
            init_hi_reg <= pwdata[15:4];
            init_lo_reg <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            od_en_reg    <= 1'b0;
            od_use_reg   <= 1'b0;
            od_ratio_reg <= 6'h00;
        end else if (wr_en && idx == `CCG_IDX_GEN4) begin
            od_en_reg    <= pwdata[`CCG_GEN4_EN_BIT];
            od_use_reg   <= pwdata[`CCG_GEN4_USE_BIT];
            od_ratio_reg <= pwdata[5:0];
        end
    end

    // reserved codes are stored as written and hold the pin low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_code_reg <= `CCG_PINSRC_RESET;
        end else if (wr_en && idx == `CCG_IDX_PINSRC) begin
            src_code_reg <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_sel_reg <= 1'b0;
        end else if (wr_en && idx == `CCG_IDX_CFG2) begin
            sys_sel_reg <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_off_reg <= `CCG_MISC_OFF_RESET;
            pwrdn_reg   <= `CCG_MISC_PD_RESET;
            clr_n_reg   <= `CCG_MISC_CLR_RESET;
        end else if (wr_en && idx == `CCG_IDX_MISC) begin
            clk_off_reg <= pwdata[`CCG_MISC_OFF_BIT];
            pwrdn_reg   <= pwdata[`CCG_MISC_PD_BIT];
            clr_n_reg   <= pwdata[`CCG_MISC_CLR_BIT];
        end
    end
    assign system_source_select = sys_sel_reg;
    assign pll_power_down       = pwrdn_reg;
    assign generator_clear_n    = clr_n_reg;
    assign clock_out_oe         = !clk_off_reg;

    ccg_lock_monitor #(
        .LOCK_CYCLES (LOCK_CYCLES)
    ) u_lock (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (pwrdn_reg || !clr_n_reg),
        .locked  (locked)
    );

    assign dif.enable  = od_en_reg;
    assign dif.use_div = od_use_reg;
    assign dif.ratio   = od_ratio_reg;
    assign dif.clear   = !clr_n_reg;

    ccg_out_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .dif     (dif.div)
    );

    // pin source switch: only at a low phase of each source that is not constant, so no runt pulse reaches the pin
    assign want_kind = src_kind(src_code_reg);
    always_comb begin
        case (want_kind)
            ccg_pkg::SRC_PLL:  want_lvl = dif.level;
            ccg_pkg::SRC_HIGH: want_lvl = 1'b1;
            ccg_pkg::SRC_USB:  want_lvl = usb_pll_clock;
            ccg_pkg::SRC_SYS:  want_lvl = system_clock;
            default:           want_lvl = 1'b0;
        endcase
        case (active_kind_reg)
            ccg_pkg::SRC_PLL:  act_lvl = dif.level;
            ccg_pkg::SRC_HIGH: act_lvl = 1'b1;
            ccg_pkg::SRC_USB:  act_lvl = usb_pll_clock;
            ccg_pkg::SRC_SYS:  act_lvl = system_clock;
            default:           act_lvl = 1'b0;
        endcase
    end
    assign switch_ok = (want_kind != active_kind_reg)
                     && (!pin_reg || is_const(active_kind_reg))
                     && (!want_lvl || is_const(want_kind));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_kind_reg <= ccg_pkg::SRC_SYS;
        end else if (switch_ok) begin
            active_kind_reg <= want_kind;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= act_lvl;
        end
    end
    assign clock_out_pin = pin_reg;

    // interrupts: lock reached, pin source switched; a new event beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_d_reg <= 1'b0;
        end else begin
            locked_d_reg <= locked;
        end
    end
    assign events[`CCG_IRQ_LOCK_BIT]   = locked && !locked_d_reg;
    assign events[`CCG_IRQ_SWITCH_BIT] = switch_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_reg <= 2'h0;
        end else if (wr_en && idx == `CCG_IDX_IRQCLR) begin
            irq_st_reg <= (irq_st_reg & ~pwdata[1:0]) | events;
        end else begin
            irq_st_reg <= irq_st_reg | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_reg <= 2'h0;
        end else if (wr_en && idx == `CCG_IDX_IRQEN) begin
            irq_en_reg <= pwdata[1:0];
        end
    end
    assign irq = |(irq_st_reg & irq_en_reg);

    // checking aid: cycles between divider ticks, trusted only with a steady config
    logic [7:0] gap_reg;
    logic       gap_ok_reg;
    logic [7:0] exp_gap;
    logic [6:0] exp_r4;
    assign exp_r4  = {1'b0, od_ratio_reg} + 7'h04;
    assign exp_gap = !od_en_reg ? 8'h01 : (!od_use_reg ? 8'h02 : {exp_r4, 1'b0});
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_reg    <= 8'h00;
            gap_ok_reg <= 1'b0;
        end else begin
            gap_reg    <= dif.tick ? 8'h01 : ((gap_reg == 8'hFF) ? gap_reg : gap_reg + 8'h01);
            gap_ok_reg <= !(wr_en && idx == `CCG_IDX_GEN4) && clr_n_reg && (dif.tick || gap_ok_reg);
        end
    end

    bypass_period_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (dif.tick && gap_ok_reg && !od_en_reg) |-> gap_reg == 8'h01)
        else $error("bypassed divider not toggling every cycle");
    half_only_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (dif.tick && gap_ok_reg && od_en_reg && !od_use_reg) |-> gap_reg == 8'h02)
        else $error("fixed halving period wrong");
    ratio_period_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (dif.tick && gap_ok_reg && od_en_reg && od_use_reg) |-> gap_reg == exp_gap)
        else $error("programmable divider period wrong");
    pin_off_float_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && idx == `CCG_IDX_MISC) |=> clock_out_oe == !$past(pwdata[`CCG_MISC_OFF_BIT]))
        else $error("clock pin enable does not follow clock-off flag");
    pin_high_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (active_kind_reg == ccg_pkg::SRC_HIGH) ##1 (active_kind_reg == ccg_pkg::SRC_HIGH) |-> clock_out_pin)
        else $error("pin not held high");
    pin_pll_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (active_kind_reg == ccg_pkg::SRC_PLL) |=> clock_out_pin == $past(dif.level))
        else $error("pin not following pll output");
    pin_usb_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (active_kind_reg == ccg_pkg::SRC_USB) |=> clock_out_pin == $past(usb_pll_clock))
        else $error("pin not following usb clock");
    source_state_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && idx == `CCG_IDX_CFG2 && paddr[1:0] == 2'h0)
        |=> prdata[5:4] == {$past(select_pin), $past(sys_sel_reg)})
        else $error("system source field wrong");
    glitch_free_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (active_kind_reg != $past(active_kind_reg))
        |-> (!$past(clock_out_pin) || is_const($past(active_kind_reg)))
            && active_kind_reg == $past(want_kind))
        else $error("pin source switched during a high phase");
    pin_low_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (active_kind_reg == ccg_pkg::SRC_LOW) ##1 (active_kind_reg == ccg_pkg::SRC_LOW) |-> !clock_out_pin)
        else $error("pin not held low");
    pin_sys_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (active_kind_reg == ccg_pkg::SRC_SYS) |=> clock_out_pin == $past(system_clock))
        else $error("pin not following system clock");
    lock_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && idx == `CCG_IDX_GEN3 && paddr[1:0] == 2'h0)
        |=> prdata[`CCG_GEN3_LOCK_BIT] == $past(locked))
        else $error("lock flag read wrong");
    cfg1_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && idx == `CCG_IDX_CFG1) |=> prdata == 32'h0000_0000)
        else $error("clock config one not reading zero");
    status_sticky_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (events != 2'h0) |=> (irq_st_reg & $past(events)) == $past(events))
        else $error("interrupt event lost");
    status_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && idx == `CCG_IDX_IRQCLR) |=> (irq_st_reg & $past(pwdata[1:0] & ~events)) == 2'h0)
        else $error("interrupt status not cleared");
    switch_event_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (active_kind_reg != $past(active_kind_reg)) |-> irq_st_reg[`CCG_IRQ_SWITCH_BIT])
        else $error("source switch not flagged");
endmodule // ccg_clock_control
`default_nettype wire

//--- sim/ccg_clock_control_tb.sv
// self-checking bench of the clock control block: registers, lock flag, divider, pin source, interrupt
// assumes the apb slave answers with pready and the pin is registered one cycle behind its source
`include "ccg_defines.svh"
`default_nettype none
module ccg_clock_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOCK = 8;
    logic        pclk, presetn, psel, penable, pwrite, sys_clk, usb_clk, sel_pin;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, mode_sel, pd, clr_n, pin, pin_oe, irq, err;
    int          err_count, checked;

    ccg_clock_control #(.LOCK_CYCLES(LOCK)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .system_clock(sys_clk), .usb_pll_clock(usb_clk), .select_pin(sel_pin),
        .system_source_select(mode_sel), .pll_power_down(pd), .generator_clear_n(clr_n),
        .clock_out_pin(pin), .clock_out_oe(pin_oe), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    // holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic t_reset_vals();
        apb(0, `CCG_IDX_CFG1, 0);   chk(rd, 32'h0000_0000, "cfg1");
        apb(0, `CCG_IDX_PINSRC, 0); chk(rd, 32'h0000_000B, "pinsrc");
        apb(0, `CCG_IDX_GEN3, 0);   chk(rd, 32'h0000_0806, "gen3");
        chk({31'h0, pin_oe}, 32'h0, "oe at boot");
        chk({30'h0, pd, clr_n}, 32'h2, "pd clr reset");
        apb(1, `CCG_IDX_CFG1, 32'h0000_0000);
        apb(0, `CCG_IDX_CFG1, 0);   chk(rd, 32'h0000_0000, "cfg1 wr");
        apb(0, 14'h1C29, 0);        chk({31'h0, err}, 32'h1, "unmapped");
        sel_pin <= 1'b1;
        apb(1, `CCG_IDX_CFG2, 32'h0000_0001);
        apb(0, `CCG_IDX_CFG2, 0);   chk(rd, 32'h0000_0035, "cfg2");
        chk({31'h0, mode_sel}, 32'h1, "mode select");
    endtask

    // lock count after power-up, its interrupt, then restart on power-down
    task automatic t_lock_irq();
        apb(1, `CCG_IDX_GEN3, 32'h0000_0806);
        apb(1, `CCG_IDX_IRQEN, 32'h0000_0001);
        apb(1, `CCG_IDX_MISC, 32'h0000_0004);
        chk({31'h0, pin_oe}, 32'h1, "oe on");
        chk({30'h0, pd, clr_n}, 32'h1, "pd clr run");
        apb(0, `CCG_IDX_GEN3, 0);   chk(rd, 32'h0000_0806, "unlocked");
        repeat (LOCK + 4) @(posedge pclk);
        apb(0, `CCG_IDX_GEN3, 0);   chk(rd, 32'h0000_080E, "locked");
        chk({31'h0, irq}, 32'h1, "irq set");
        apb(1, `CCG_IDX_IRQEN, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1, `CCG_IDX_IRQEN, 32'h0000_0001);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        apb(1, `CCG_IDX_IRQCLR, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        apb(1, `CCG_IDX_MISC, 32'h0000_0006);
        apb(0, `CCG_IDX_GEN3, 0);   chk(rd, 32'h0000_0806, "restart");
        apb(1, `CCG_IDX_MISC, 32'h0000_0004);
    endtask

    // every legal source code, with the two external levels given
    task automatic t_sources(input logic u, input logic s);
        logic a, b;
        for (int c = 0; c < 16; c++) begin
            if (c == 9 || c == 13) continue;
            // levels low while switching: the pin changes source only at a low phase unless a source is constant
            usb_clk <= 1'b0;
            sys_clk <= 1'b0;
            apb(1, `CCG_IDX_PINSRC, 32'(c));
            repeat (4) @(posedge pclk);
            usb_clk <= u;
            sys_clk <= s;
            repeat (6) @(negedge pclk);
            a = pin;
            @(negedge pclk);
            b = pin;
            if (c % 2 == 0) chk({31'h0, a ^ b}, 32'h1, "pll source");
            else if (c == 1) chk({30'h0, a, b}, 32'h3, "high");
            else if (c == 7 || c == 15) chk({30'h0, a, b}, {30'h0, u, u}, "usb");
            else if (c == 11) chk({30'h0, a, b}, {30'h0, s, s}, "sys");
            else chk({30'h0, a, b}, 32'h0, "low");
            @(posedge pclk);
        end
    endtask

    // cycles between pin changes with the pll source selected
    task automatic t_div(input logic [31:0] gen4, input int exp);
        int   n;
        logic p;
        apb(1, `CCG_IDX_GEN4, gen4);
        repeat (4) @(negedge pclk);
        p = pin;
        for (int i = 0; i < 200 && pin === p; i++) @(negedge pclk);
        p = pin;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (pin === p && n < 200);
        chk(32'(n), 32'(exp), "half period");
        @(posedge pclk);
    endtask

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #2_000_000;
        err_count++;
        close_out();
    end

    initial begin
        err_count = 0;
        checked   = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        sys_clk = 1'b0;
        usb_clk = 1'b0;
        sel_pin = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_vals();
        t_lock_irq();
        t_sources(1'b1, 1'b0);
        t_sources(1'b0, 1'b1);
        apb(1, `CCG_IDX_PINSRC, 32'h0000_0000);
        t_div(32'h0000_0100, 1);
        t_div(32'h0000_0200, 2);
        t_div(32'h0000_0302, 12);
        t_div(32'h0000_0300, 8);
        close_out();
    end
endmodule // ccg_clock_control_tb
`default_nettype wire
